// ==== design/lpm_pkg.sv ====
// Constants and types shared by the low-power mode controller
package lpm_pkg;

    // ==============================================================
    // Register map (byte offsets) and field positions
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_TMR_A_MODE = 4'h4;
    localparam logic [3:0] OFS_CLK_SEL = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    localparam int LOW_SPEED_BIT = 0;
    localparam int DIRECT_XFER_BIT = 3;
    localparam int WATCH_SEL_BIT = 3;
    localparam int SUBCLK_HALT_BIT = 3;
    localparam int RAM_VALID_BIT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==============================================================
    // Operating modes
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b000,
        MODE_STANDBY = 3'b001,
        MODE_STOP = 3'b010,
        MODE_WATCH = 3'b011,
        MODE_SUBACTIVE = 3'b100
    } mode_t;

    // ==============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_SETTLE_NS = 2000;
    localparam int SETTLE_CYCLES =
        (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] EXT_WAKE_FRAMES = 2'h2;
    localparam logic [1:0] DIRECT_WAKE_FRAMES = 2'h1;

endpackage : lpm_pkg

// ==== design/low_power_mode_controller.sv ====
// Operating-mode controller with AXI4-Lite register access
//
// How it works
// - Active mode runs every function from the main oscillator.
// - Standby instruction in active mode enters standby.
// - Standby keeps both oscillators, stops CPU clock, holds state and outputs.
// - Standby keeps interrupts, timers, serial channels and A/D running.
// - Interrupt ends standby; resume at the next instruction in active.
// - After wake, interrupt serviced if master enable set, else pending.
// - Reset ending standby performs a full reset.
// - Halt in active with watch select clear enters stop.
// - Stop halts main oscillator; sub oscillator halts if its halt bit set.
// - Stop holds CPU, timers, serial, A/D and I/O in reset.
// - Stop floats every output pin.
// - Stop exit keeps RAM; CPU working registers become invalid.
// - Watch entered by halt with watch select, or halt/standby in subactive.
// - Watch runs timer A on sub clock and external-clock serial shift; others stop, state held.
// - Watch: external-clock serial still shifts but raises no interrupt.
// - Timer A or external interrupt ends watch; low speed flag picks target.
// - Watch wake: settle (to active only) after timer A; two frames plus that settle after ext.
// - Subactive runs on sub clock, main oscillator off, A/D stopped.
// - Subactive exists only when the build option enables it.
// - Direct transfer: halt/standby in subactive goes straight to active.
// - Standby/watch hold port outputs; stop floats them.
// - Direct transfer selected by low speed clear and direct flag set.
// - Direct flag writable to one only in subactive, cleared in active.
// - Stop exit by release sets RAM-valid, by reset clears it.
// - Pending unmasked interrupt with master enable clear cancels halt/standby.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_controller
    import lpm_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter bit SUBACTIVE_EN = 1'b1,
    parameter int SETTLE_CYC = SETTLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_op,
    input wire logic standby_op,
    input wire logic irq_pending,
    input wire logic int_master_enable,
    input wire logic timer_a_irq,
    input wire logic first_ext_interrupt,
    input wire logic frame_tick,
    input wire logic halt_release_input_n,
    output logic [2:0] mode_q,
    output logic main_osc_en_q,
    output logic sub_osc_en_q,
    output logic cpu_clk_en_q,
    output logic cpu_on_sub_clk_q,
    output logic cpu_reset_q,
    output logic timer_a_run_q,
    output logic timer_bcd_run_q,
    output logic serial_run_q,
    output logic serial_ext_shift_q,
    output logic serial_irq_en_q,
    output logic adc_run_q,
    output logic periph_reset_q,
    output logic io_hold_q,
    output logic io_hiz_q,
    output logic resume_next_q,
    output logic service_irq_q,
    output logic restart_q,
    output logic ram_valid_q
);

    // ==============================================================
    // Elaboration checks; refuse sizes the counters cannot serve
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
    begin : g_bad_settle
        $error("SETTLE_CYC out of range");
    end
    if (ADDR_W < 4 || ADDR_W > 32)
    begin : g_bad_addr
        $error("ADDR_W out of range");
    end

    localparam logic [15:0] SETTLE = 16'(SETTLE_CYC);

    mode_t state_q;
    mode_t mode_d;
    mode_t wake_tgt_q;
    mode_t tgt_d;
    logic low_speed_q;
    logic dtf_q;
    logic watch_sel_q;
    logic subclk_halt_q;
    logic hr_s1_q;
    logic hr_s2_q;
    logic [15:0] hr_cnt_q;
    logic wake_q;
    logic [1:0] frames_q;
    logic [15:0] settle_q;
    logic start_wake;
    logic [1:0] start_frames;
    logic [15:0] start_settle;
    logic wake_done;
    logic cancel_op;
    logic resume_d;
    logic restart_d;
    logic warm_d;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;

    // ==============================================================
    // Halt-release pin synchroniser
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hr_s1_q <= 1'b1;
            hr_s2_q <= 1'b1;
        end
        else
        begin
            hr_s1_q <= halt_release_input_n;
            hr_s2_q <= hr_s1_q;
        end
    end

    // Release must stay low a full settle time; ignored outside stop
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_q != MODE_STOP || hr_s2_q)
            hr_cnt_q <= 16'h0000;
        else if (hr_cnt_q != SETTLE)
            hr_cnt_q <= hr_cnt_q + 16'h0001;
    end

    // ==============================================================
    // Mode transitions
    assign cancel_op = irq_pending && !int_master_enable;
    assign wake_done = wake_q && frames_q == 2'h0 && settle_q == 16'h0000;

    always_comb
    begin
        mode_d = state_q;
        tgt_d = wake_tgt_q;
        start_wake = 1'b0;
        start_frames = 2'h0;
        start_settle = 16'h0000;
        resume_d = 1'b0;
        restart_d = 1'b0;
        case (state_q)
            MODE_ACTIVE:
            begin
                if (!cancel_op && standby_op)
                    mode_d = MODE_STANDBY;
                else if (!cancel_op && halt_op)
                    mode_d = watch_sel_q ? MODE_WATCH : MODE_STOP;
            end
            MODE_STANDBY:
            begin
                if (irq_pending)
                begin
                    mode_d = MODE_ACTIVE;
                    resume_d = 1'b1;
                end
            end
            MODE_STOP:
            begin
                if (hr_cnt_q == SETTLE)
                begin
                    mode_d = MODE_ACTIVE;
                    restart_d = 1'b1;
                end
            end
            MODE_WATCH:
            begin
                if (wake_done)
                begin
                    mode_d = wake_tgt_q;
                    resume_d = 1'b1;
                end
                else if (!wake_q && (timer_a_irq || first_ext_interrupt))
                begin
                    start_wake = 1'b1;
                    tgt_d = (low_speed_q && SUBACTIVE_EN) ?
                        MODE_SUBACTIVE : MODE_ACTIVE;
                    // Timer A wins a tie: it is frame aligned already
                    start_frames = timer_a_irq ? 2'h0 : EXT_WAKE_FRAMES;
                    start_settle = (tgt_d == MODE_ACTIVE) ?
                        SETTLE : 16'h0000;
                end
            end
            MODE_SUBACTIVE:
            begin
                if (wake_done)
                begin
                    mode_d = MODE_ACTIVE;
                    resume_d = 1'b1;
                end
                else if (!wake_q && !cancel_op && (halt_op || standby_op))
                begin
                    if (!low_speed_q && dtf_q)
                    begin
                        start_wake = 1'b1;
                        tgt_d = MODE_ACTIVE;
                        start_frames = DIRECT_WAKE_FRAMES;
                        start_settle = SETTLE;
                    end
                    else
                        mode_d = MODE_WATCH;
                end
            end
            default:
                mode_d = MODE_ACTIVE;
        endcase
    end

    // Mode register; reset always lands in active
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= MODE_ACTIVE;
        else
            state_q <= mode_d;
    end

    // ==============================================================
    // Wake-up timer: frames first, then oscillator settling
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_q <= 1'b0;
            frames_q <= 2'h0;
            settle_q <= 16'h0000;
            wake_tgt_q <= MODE_ACTIVE;
        end
        else if (start_wake)
        begin
            wake_q <= 1'b1;
            frames_q <= start_frames;
            settle_q <= start_settle;
            wake_tgt_q <= tgt_d;
        end
        else if (wake_done)
            wake_q <= 1'b0;
        else if (wake_q && frames_q != 2'h0)
        begin
            if (frame_tick)
                frames_q <= frames_q - 2'h1;
        end
        else if (wake_q)
            settle_q <= settle_q - 16'h0001;
    end

    // ==============================================================
    // Per-mode enables, registered from the next mode
    assign warm_d = wake_q && frames_q == 2'h0 &&
        wake_tgt_q == MODE_ACTIVE;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_osc_en_q <= 1'b1;
            sub_osc_en_q <= 1'b1;
            cpu_clk_en_q <= 1'b1;
            cpu_on_sub_clk_q <= 1'b0;
            cpu_reset_q <= 1'b0;
            timer_a_run_q <= 1'b1;
            timer_bcd_run_q <= 1'b1;
            serial_run_q <= 1'b1;
            serial_ext_shift_q <= 1'b1;
            serial_irq_en_q <= 1'b1;
            adc_run_q <= 1'b1;
            periph_reset_q <= 1'b0;
            io_hold_q <= 1'b0;
            io_hiz_q <= 1'b0;
            mode_q <= MODE_ACTIVE;
        end
        else
        begin
            mode_q <= mode_d;
            main_osc_en_q <= mode_d == MODE_ACTIVE ||
                mode_d == MODE_STANDBY || warm_d;
            sub_osc_en_q <= !(mode_d == MODE_STOP && subclk_halt_q);
            cpu_clk_en_q <= mode_d == MODE_ACTIVE ||
                mode_d == MODE_SUBACTIVE;
            cpu_on_sub_clk_q <= mode_d == MODE_SUBACTIVE;
            cpu_reset_q <= mode_d == MODE_STOP;
            timer_a_run_q <= mode_d != MODE_STOP;
            timer_bcd_run_q <= mode_d != MODE_STOP &&
                mode_d != MODE_WATCH;
            serial_run_q <= mode_d != MODE_STOP &&
                mode_d != MODE_WATCH;
            serial_ext_shift_q <= mode_d != MODE_STOP;
            serial_irq_en_q <= mode_d != MODE_STOP &&
                mode_d != MODE_WATCH;
            adc_run_q <= mode_d == MODE_ACTIVE ||
                mode_d == MODE_STANDBY;
            periph_reset_q <= mode_d == MODE_STOP;
            io_hold_q <= mode_d == MODE_STANDBY ||
                mode_d == MODE_WATCH;
            io_hiz_q <= mode_d == MODE_STOP;
        end
    end

    // Wake pulses; the CPU decides how to use them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            resume_next_q <= 1'b0;
            service_irq_q <= 1'b0;
            restart_q <= 1'b0;
        end
        else
        begin
            resume_next_q <= resume_d;
            service_irq_q <= resume_d && int_master_enable;
            restart_q <= restart_d;
        end
    end

    // RAM-valid: reset clears, release exit sets
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ram_valid_q <= 1'b0;
        else if (restart_d)
            ram_valid_q <= 1'b1;
    end

    // ==============================================================
    // AXI4-Lite write path: address and data taken in either order
    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_hit = awaddr_q[ADDR_W-1:4] == '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Control fields; only byte lane 0 carries bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_speed_q <= 1'b0;
            watch_sel_q <= 1'b0;
            subclk_halt_q <= 1'b0;
        end
        else if (wr_go && wr_hit && wstrb_q[0])
        begin
            if (awaddr_q[3:0] == OFS_CTRL)
                low_speed_q <= wdata_q[LOW_SPEED_BIT];
            if (awaddr_q[3:0] == OFS_TMR_A_MODE)
                watch_sel_q <= wdata_q[WATCH_SEL_BIT];
            if (awaddr_q[3:0] == OFS_CLK_SEL)
                subclk_halt_q <= wdata_q[SUBCLK_HALT_BIT];
        end
    end

    // Direct flag: a one sticks only in subactive, active wipes it
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_q == MODE_ACTIVE)
            dtf_q <= 1'b0;
        else if (wr_go && wr_hit && wstrb_q[0] &&
                 awaddr_q[3:0] == OFS_CTRL)
            dtf_q <= wdata_q[DIRECT_XFER_BIT] &&
                state_q == MODE_SUBACTIVE;
    end

    // ==============================================================
    // AXI4-Lite read path, one cycle to answer
    assign rd_hit = s_axi_araddr[ADDR_W-1:4] == '0;

    always_comb
    begin
        rd_word = 32'h00000000;
        case (s_axi_araddr[3:0])
            OFS_CTRL:
            begin
                rd_word[LOW_SPEED_BIT] = low_speed_q;
                rd_word[DIRECT_XFER_BIT] = dtf_q;
            end
            OFS_TMR_A_MODE:
                rd_word[WATCH_SEL_BIT] = watch_sel_q;
            OFS_CLK_SEL:
                rd_word[SUBCLK_HALT_BIT] = subclk_halt_q;
            OFS_STATUS:
            begin
                rd_word[2:0] = state_q;
                rd_word[RAM_VALID_BIT] = ram_valid_q;
            end
            default:
                rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_word : 32'h00000000;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==============================================================
    // Assertions and covers
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_active_main_clk: assert property (
        state_q == MODE_ACTIVE |-> main_osc_en_q && cpu_clk_en_q)
        else $error("active mode without main clock");

    chk_standby_entry: assert property (
        state_q == MODE_ACTIVE && standby_op && !cancel_op
        |=> state_q == MODE_STANDBY && !cpu_clk_en_q && sub_osc_en_q)
        else $error("standby not entered");

    chk_standby_wake: assert property (
        state_q == MODE_STANDBY && irq_pending
        |=> state_q == MODE_ACTIVE && resume_next_q)
        else $error("standby wake failed");

    chk_service_gate: assert property (
        resume_next_q |-> service_irq_q == $past(int_master_enable))
        else $error("service pulse wrong");

    chk_stop_entry: assert property (
        state_q == MODE_ACTIVE && halt_op && !standby_op && !cancel_op &&
        !watch_sel_q |=> state_q == MODE_STOP)
        else $error("stop not entered");

    chk_stop_pins: assert property (
        state_q == MODE_STOP |-> io_hiz_q && cpu_reset_q && !main_osc_en_q)
        else $error("stop outputs wrong");

    chk_watch_units: assert property (
        state_q == MODE_WATCH |-> timer_a_run_q && !serial_run_q &&
        serial_ext_shift_q && !serial_irq_en_q && !timer_bcd_run_q)
        else $error("watch enables wrong");

    chk_op_cancel: assert property (
        state_q == MODE_ACTIVE && cancel_op && (halt_op || standby_op)
        |=> state_q == MODE_ACTIVE)
        else $error("cancelled op changed mode");

    chk_direct_flag: assert property (
        state_q == MODE_ACTIVE ##1 state_q == MODE_ACTIVE |-> !dtf_q)
        else $error("direct flag set in active");

    chk_ram_valid: assert property (
        restart_q |-> ram_valid_q && state_q == MODE_ACTIVE)
        else $error("ram valid not set on release exit");

    chk_no_subactive: assert property (
        !SUBACTIVE_EN |-> state_q != MODE_SUBACTIVE)
        else $error("subactive without option");

    cov_standby_cycle: cover property (
        state_q == MODE_STANDBY ##1 state_q == MODE_ACTIVE);
    cov_stop_release: cover property (restart_q);
    cov_watch_ext_wake: cover property (
        state_q == MODE_WATCH && start_wake && first_ext_interrupt);
    cov_direct_xfer: cover property (
        state_q == MODE_SUBACTIVE ##1 state_q == MODE_ACTIVE);

endmodule : low_power_mode_controller

`default_nettype wire

// ==== verification/lpm_wake_partner.sv ====
// Behavioural far side: halt-release pin and interrupt frame strobe
`timescale 1ns/1ps
`default_nettype none

module lpm_wake_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic release_req,
    input wire logic [7:0] hold_cyc,
    output logic halt_release_input_n,
    output logic frame_tick
);
    logic [7:0] hold_q;
    logic [3:0] frame_q;

    // ==========================================================
    // Release pin held low a full settle span, then let go high
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hold_q <= 8'h00;
        else if (release_req)
            hold_q <= hold_cyc;
        else if (hold_q != 8'h00)
            hold_q <= hold_q - 8'h01;
    end
    assign halt_release_input_n = (hold_q == 8'h00);

    // Frame strobe every 16 cycles, free running like the time base
    always_ff @(posedge aclk)
    begin
        frame_q <= aresetn ? frame_q + 4'h1 : 4'h0;
        frame_tick <= aresetn && (frame_q == 4'hf);
    end
endmodule : lpm_wake_partner
`default_nettype wire

// ==== verification/low_power_mode_controller_tb.sv ====
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module low_power_mode_controller_tb;
    import lpm_pkg::*;
    localparam int SET = 4;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, release_req;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic halt_op, standby_op, irq_pending, int_master_enable, timer_a_irq;
    logic first_ext_interrupt, frame_tick, halt_release_input_n, svc, rst, res;
    logic [2:0] mode_q;
    logic main_osc_en_q, sub_osc_en_q, cpu_clk_en_q, cpu_on_sub_clk_q;
    logic cpu_reset_q, timer_a_run_q, timer_bcd_run_q, serial_run_q;
    logic serial_ext_shift_q, serial_irq_en_q, adc_run_q, periph_reset_q;
    logic io_hold_q, io_hiz_q, resume_next_q, service_irq_q, restart_q;
    logic ram_valid_q;
    integer failures = 0, total_checks = 0, wt, seed = 32'haf42cdf5;

    low_power_mode_controller #(.SETTLE_CYC(SET)) u_low_power_mode_controller
        (.*);
    lpm_wake_partner u_lpm_wake_partner (.aclk(aclk), .aresetn(aresetn),
        .release_req(release_req), .hold_cyc(8'h0a),
        .halt_release_input_n(halt_release_input_n), .frame_tick(frame_tick));

    // ==========================================================
    // Clock and watchdog
    initial
    begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        test_done();
    end

    // ==========================================================
    // Bus and stimulus tasks; each starts at an edge so no signal
    // is driven twice in one time step
    task automatic axw(input logic [7:0] a, input logic [3:0] f);
        bit busy;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= {$random(seed)} & 32'hfffffff0 | 32'(f);
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            busy = 1;
            while (busy)
            begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 0;
                if (s_axi_wready) s_axi_wvalid <= 0;
                busy = !s_axi_bvalid;
            end
            s_axi_bready <= 0;
            `CHK("bresp", RESP_OKAY, s_axi_bresp)
        end
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] e);
        bit busy;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            busy = 1;
            while (busy)
            begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 0;
                busy = !s_axi_rvalid;
            end
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            s_axi_rready <= 0;
            `CHK("rdata", e, rd)
            `CHK("rresp", (a > 8'h0c) ? RESP_SLVERR : RESP_OKAY, rr)
        end
    endtask : axr

    task automatic pulse(input int k);
        begin
            @(posedge aclk);
            // Code 4 halt, 3 standby, 2 external, 1 timer A, 0 release
            {halt_op, standby_op, first_ext_interrupt, timer_a_irq,
                release_req} <= 5'h01 << k;
            @(posedge aclk);
            {halt_op, standby_op, timer_a_irq, first_ext_interrupt,
                release_req} <= 5'h0;
        end
    endtask : pulse

    // Reference mode table compared with mode_q and eleven per-mode enables
    task automatic go(input int m);
        begin
            wt = 0;
            while (mode_q !== 3'(m))
            begin
                @(posedge aclk);
                wt++;
            end
            svc = service_irq_q;
            rst = restart_q;
            res = resume_next_q;
            `CHK("mode", 3'(m), mode_q)
            `CHK("main_osc", 1'(m < 2), main_osc_en_q)
            `CHK("cpu_clk", 1'(m == 0 || m == 4), cpu_clk_en_q)
            `CHK("adc", 1'(m < 2), adc_run_q)
            `CHK("tmr_bcd", 1'(m < 2 || m == 4), timer_bcd_run_q)
            `CHK("hiz", 1'(m == 2), io_hiz_q)
            `CHK("prst", 1'(m == 2), periph_reset_q)
            `CHK("cpu_rst", 1'(m == 2), cpu_reset_q)
            `CHK("hold", 1'(m == 1 || m == 3), io_hold_q)
            `CHK("sub_clk", 1'(m == 4), cpu_on_sub_clk_q)
            `CHK("serial", 1'(m < 2 || m == 4), serial_run_q)
            `CHK("tmr_a", 1'(m != 2), timer_a_run_q)
        end
    endtask : go

    task automatic test_done();
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask : test_done

    // ==========================================================
    // Main sequence
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} <= 0;
        {s_axi_rready, halt_op, standby_op, timer_a_irq} <= 0;
        {first_ext_interrupt, release_req, irq_pending} <= 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 0;
        s_axi_wstrb <= 4'hf;
        int_master_enable <= 0;
        aresetn <= 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        go(0);
        axr(8'h0c, 32'h0);
        axr(8'h40, 32'h0);
        // Pending unmasked request with enable clear cancels halt
        irq_pending <= 1;
        pulse(4);
        repeat (3) @(posedge aclk);
        go(0);
        for (int i = 0; i < 2; i++)
        begin
            irq_pending <= 0;
            int_master_enable <= 1'(i);
            pulse(3);
            go(1);
            irq_pending <= 1;
            go(0);
            `CHK("svc", 1'(i), svc)
            `CHK("resume", 1'b1, res)
        end
        irq_pending <= 0;
        axw(8'h04, 4'h0);
        pulse(4);
        go(2);
        `CHK("sub_osc", 1'b1, sub_osc_en_q)
        pulse(0);
        go(0);
        `CHK("restart", 1'b1, rst)
        `CHK("ram_valid", 1'b1, ram_valid_q)
        axr(8'h0c, 32'h8);
        axw(8'h08, 4'h8);
        pulse(4);
        go(2);
        `CHK("sub_osc", 1'b0, sub_osc_en_q)
        aresetn <= 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        go(0);
        `CHK("ram_valid", 1'b0, ram_valid_q)
        axr(8'h0c, 32'h0);
        axw(8'h04, 4'h8);
        axw(8'h00, 4'h0);
        for (int k = 1; k < 3; k++)
        begin
            pulse(4);
            go(3);
            pulse(k);
            go(0);
            `CHK("wake", 1'b1, 1'(wt >= SET + 16 * (k - 1) &&
                wt <= SET + 32 * (k - 1) + 4))
        end
        axw(8'h00, 4'h1);
        pulse(4);
        go(3);
        pulse(2);
        go(4);
        pulse(3);
        go(3);
        pulse(2);
        go(4);
        axw(8'h00, 4'h8);
        axr(8'h00, 32'h8);
        pulse(3);
        go(0);
        axr(8'h00, 32'h0);
        test_done();
    end
endmodule : low_power_mode_controller_tb
`default_nettype wire
